// ### irqg_checker.sv
// Port checker for the interrupt request generator.
`timescale 1ns/10ps
`default_nettype none
module irqg_checker (
    // Clock, reset, bus and request ports.
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [8:0]  host_req_o,
    input wire logic        irq_o
);
    logic [11:0] gap;
    logic        seen;
    wire         acc = psel_i && penable_i;
    // Counts cycles since the last request, saturating.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap  <= 12'h000;
            seen <= 1'b0;
        end else begin
            gap  <= (|host_req_o) ? 12'h000 : gap + {11'h000, gap != 12'hFFF};
            seen <= seen | (|host_req_o);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_err_decode: assert property (acc && paddr_i[1:0] == 2'b00 |->
        pslverr_o == (paddr_i > 12'h014)) else $error("bad pslverr");
    a_err_idle: assert property (!acc |-> !pslverr_o) else $error("pslverr outside access");
    a_rdata_stand: assert property ($changed(prdata_o) |->
        $past(psel_i && !penable_i && !pwrite_i)) else $error("prdata moved");
    a_req_gap: assert property (|host_req_o && seen |-> gap >= 12'h4E1)
        else $error("requests too close");
    a_req_pulse: assert property (|host_req_o |=> (host_req_o == 9'h000) [*8])
        else $error("request not a pulse");
    a_irq_rise: assert property ($rose(irq_o) |-> |host_req_o || $past(acc && pwrite_i))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(acc && pwrite_i))
        else $error("irq fell without write");
endmodule
bind irqg_top irqg_checker u_chk (.*);
`default_nettype wire

// ### irqg_host.sv
// Host model that services issued requests by vector priority.
`timescale 1ns/10ps
`default_nettype none
module irqg_host (
    // Clock, reset, requests in, serviced vector out.
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [8:0] host_req_i,
    output var  logic [3:0] svc_o,
    output var  logic       svc_vld_o
);
    logic [8:0] pend;
    // Collects requests and serves the lowest vector first.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend      <= 9'h000;
            svc_o     <= 4'h0;
            svc_vld_o <= 1'b0;
        end else begin
            svc_vld_o <= |pend;
            for (int i = 8; i >= 0; i--) begin
                if (pend[i]) svc_o <= 4'(i + 1);
            end
            pend <= (pend & ~(pend & (~pend + 9'h001))) | host_req_i;
        end
    end
endmodule
`default_nettype wire

// ### irqg_map.vh
// Register map, field layout, reset values and timing constants of the interrupt request generator.
`ifndef IRQG_MAP_VH
`define IRQG_MAP_VH

// Register byte offsets.
`define IRQG_CTRL_OFS       12'h000
`define IRQG_VEC_LO_OFS     12'h004
`define IRQG_VEC_HI_OFS     12'h008
`define IRQG_STAT_OFS       12'h00C
`define IRQG_MASK_OFS       12'h010
`define IRQG_PEND_OFS       12'h014

// Control register fields.
`define IRQG_CTRL_LOGEN_BIT 0
`define IRQG_CTRL_SYNC_BIT  1
`define IRQG_CTRL_ADLOG_BIT 2

// Vector field width; source n uses bits 4n+3..4n of the vector registers.
`define IRQG_VEC_W          4
`define IRQG_VEC_MAX        4'h9
`define IRQG_NSRC           9

// Reset values.
`define IRQG_CTRL_RST       32'h00000000
`define IRQG_VEC_RST        36'h000000000
`define IRQG_MASK_RST       9'h000

// Issue intervals in microseconds and the clock rate in MHz.
`define IRQG_CLK_MHZ        25
`define IRQG_FAST_US        50
`define IRQG_SLOW_US        100
`define IRQG_FAST_CYC       (`IRQG_FAST_US * `IRQG_CLK_MHZ)
`define IRQG_SLOW_CYC       (`IRQG_SLOW_US * `IRQG_CLK_MHZ)

// Last count of each interval, one less than its length in cycles.
`define IRQG_FAST_MAX       12'h4E1
`define IRQG_SLOW_MAX       12'h9C3

`endif

// ### irqg_top.v
// Interrupt request generator with APB register access.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "irqg_map.vh"

// Notes on behaviour
// [R01] A rising signal on any of eight terminals raises a request.
// [R02] A full continuous logging block raises a request.
// [R03] At most nine sources, each tied to one host vector.
// [R04] Terminals 0 to 7 and logging-full each take a vector 1 to 9.
// [R05] Counter blocks drive the terminals on event or compare match.
// [R06] Software should program a nonzero compare value.
// [R07] A source without a vector never raises a request.
// [R08] Logging-full needs its own enable besides a vector.
// [R09] A new occurrence after service raises a new request.
// [R10] Requests are issued on a fixed 50 us interval.
// [R11] Repeats of a source within one interval are dropped.
// [R12] Sync high-speed mode or analog logging slows issue to 100 us.
// [R13] Cause to request delay stays within 200 us while logging.
// [R14] The host services simultaneous requests by vector priority.
// [R15] A pending flag per source is set on occurrence, cleared on issue.
module irqg_top (
    // Clock and reset.
    input  wire        clk_i,
    input  wire        rst_n_i,
    // APB slave.
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // Event sources.
    input  wire [7:0]  si_term_i,
    input  wire        log_full_i,
    // Requests toward the host, one per vector 1 to 9 at bit index vector-1.
    output reg  [8:0]  host_req_o,
    // Level interrupt from sticky status.
    output wire        irq_o
);

    // Sources 0 to 7 are the terminals and source 8 is the logging-full condition.
    // Each source passes a synchroniser and an edge filter, is gated by its
    // vector and enables, and waits in a pending flag until the interval end.
    // At that end every pending source with a legal vector leaves as one request pulse on the bit
    // of its vector, and its status bit is set for the level interrupt.
    // Repeats inside one interval merge into the single pending flag.
    reg  [31:0] ctrl;
    reg  [35:0] vec_map;
    reg  [8:0]  stat;
    reg  [8:0]  mask;
    reg  [8:0]  pend;
    reg  [11:0] tick_cnt;
    reg  [7:0]  si_s1;
    reg  [7:0]  si_s2;
    reg  [7:0]  si_s3;
    reg         lf_s1;
    reg         lf_s2;
    reg         lf_s3;
    reg  [8:0]  src_lvl;
    wire [8:0]  src_raw;
    wire [8:0]  src_rise;
    wire [8:0]  src_ok;
    wire [8:0]  occur;
    wire        slow_mode;
    wire [11:0] tick_max;
    wire        tick;
    wire        wr_en;
    wire        rd_en;
    wire        bad_addr;
    wire [8:0]  agree;
    wire [8:0]  stat_clr;
    wire [8:0]  stat_set;
    reg  [8:0]  next_req;
    reg  [31:0] next_rdata;
    integer     i;
    integer     j;

    // Interval end counts; the slow interval is twice as long as the fast one.
    localparam [11:0] FAST_MAX = `IRQG_FAST_MAX;
    localparam [11:0] SLOW_MAX = `IRQG_SLOW_MAX;

    // Returns the vector field of one source.
    function [3:0] vec_of;
        input [35:0] map;
        input [3:0]  idx;
        begin
            vec_of = map[idx*4 +: 4];
        end
    endfunction

    // Tells whether a vector field names a legal host vector.
    function vec_valid;
        input [3:0] v;
        begin
            vec_valid = (v != 4'h0) && (v <= `IRQG_VEC_MAX);
        end
    endfunction

    // Tells whether an offset names one of the six registers.
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `IRQG_CTRL_OFS) || (a == `IRQG_VEC_LO_OFS) ||
                        (a == `IRQG_VEC_HI_OFS) || (a == `IRQG_STAT_OFS) ||
                        (a == `IRQG_MASK_OFS) || (a == `IRQG_PEND_OFS);
        end
    endfunction

    // Three-stage synchronisers; a change counts once stages two and three agree.
    // The terminals and the logging-full level come from outside this clock,
    // so the first stage may go metastable and is read by nothing else.
    // The reset values match the idle low level, so no false edge follows reset.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            si_s1 <= 8'h00;
            si_s2 <= 8'h00;
            si_s3 <= 8'h00;
            lf_s1 <= 1'b0;
            lf_s2 <= 1'b0;
            lf_s3 <= 1'b0;
        end else begin
            si_s1 <= si_term_i;
            si_s2 <= si_s1;
            si_s3 <= si_s2;
            lf_s1 <= log_full_i;
            lf_s2 <= lf_s1;
            lf_s3 <= lf_s2;
        end
    end

    // Filtered level that changes only when stages two and three agree.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_lvl <= 9'h000;
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (si_s2[i] == si_s3[i]) begin
                    src_lvl[i] <= si_s3[i];
                end
            end
            if (lf_s2 == lf_s3) begin
                src_lvl[8] <= lf_s3;
            end
        end
    end

    // Occurrence is a rising edge of the filtered level, taken per source.
    // A bit whose stages two and three disagree is still settling and
    // cannot start an occurrence; a glitch on one terminal thus neither
    // hides nor fakes the edge of another.
    assign src_raw  = {lf_s3, si_s3};
    assign agree    = ~({lf_s2, si_s2} ^ src_raw);
    assign src_rise = src_raw & agree & ~src_lvl; // [R01] [R02] [R05]

    // A source counts only with a legal vector; logging-full also needs its enable.
    genvar g;
    generate
        for (g = 0; g < `IRQG_NSRC; g = g + 1) begin : gen_ok
            // Source index in the width of the vector function's argument.
            localparam [3:0] SRC_IDX = g;
            if (g == 8) begin : gen_log
                assign src_ok[g] = vec_valid(vec_of(vec_map, SRC_IDX)) &&
                                   ctrl[`IRQG_CTRL_LOGEN_BIT]; // [R07] [R08]
            end else begin : gen_si
                assign src_ok[g] = vec_valid(vec_of(vec_map, SRC_IDX)); // [R07] [R03] [R04]
            end
        end
    endgenerate
    assign occur = src_rise & src_ok;

    // Issue interval counter; the slow interval applies in sync or analog logging mode.
    assign slow_mode = ctrl[`IRQG_CTRL_SYNC_BIT] | ctrl[`IRQG_CTRL_ADLOG_BIT]; // [R12]
    // The counter restarts from zero at each interval end, so an interval
    // spans the end count plus one cycles. A mode change takes effect at
    // once: a count already past the new end closes the interval early.
    assign tick_max  = slow_mode ? SLOW_MAX : FAST_MAX; // [R10]
    assign tick      = (tick_cnt >= tick_max);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt <= 12'h000;
        end else if (tick) begin
            tick_cnt <= 12'h000;
        end else begin
            tick_cnt <= tick_cnt + 12'h001;
        end
    end

    // Pending flags: set wins over the clear on issue, so a cause in the issue cycle waits.
    // The flags are cleared at each interval end and reloaded with any cause
    // of that same cycle, so the worst delay is one interval, well under the
    // response limit in either mode.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend <= 9'h000;
        end else if (tick) begin
            pend <= occur; // [R15] [R09] [R13]
        end else begin
            pend <= pend | occur; // [R11]
        end
    end

    // Map pending sources onto their vectors as one-cycle request pulses.
    always @* begin
        next_req = 9'h000;
        for (j = 0; j < `IRQG_NSRC; j = j + 1) begin
            // A vector cleared after the cause was taken drops the request.
            if (tick && pend[j] && vec_valid(vec_of(vec_map, j[3:0]))) begin
                next_req[vec_of(vec_map, j[3:0]) - 4'h1] = 1'b1; // [R10] [R03]
            end
        end
    end

    // Request pulses leave from flip-flops, one cycle long, in the cycle
    // after the interval end.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_req_o <= 9'h000;
        end else begin
            host_req_o <= next_req;
        end
    end

    // APB decode; zero wait states.
    // Every access completes in its first access cycle. An unmapped offset
    // answers with an error, its write is dropped and its read returns zero,
    // so a stray access can never disturb the vector map.
    assign pready_o  = 1'b1;
    assign bad_addr  = !is_mapped(paddr_i);
    assign pslverr_o = psel_i & penable_i & bad_addr;
    assign wr_en     = psel_i & penable_i & pwrite_i & ~bad_addr;
    assign rd_en     = psel_i & ~penable_i & ~pwrite_i;

    // Software registers.
    // Writes land at the access edge. Unused control bits read as zero, and
    // the upper vector register keeps only the logging source's field.
    // Changing a vector takes effect at once, also for causes already pending.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl    <= `IRQG_CTRL_RST;
            vec_map <= `IRQG_VEC_RST;
            mask    <= `IRQG_MASK_RST;
        end else if (wr_en) begin
            if (paddr_i == `IRQG_CTRL_OFS) begin
                ctrl <= {29'h0, pwdata_i[2:0]};
            end else if (paddr_i == `IRQG_VEC_LO_OFS) begin
                vec_map[31:0] <= pwdata_i;
            end else if (paddr_i == `IRQG_VEC_HI_OFS) begin
                vec_map[35:32] <= pwdata_i[3:0];
            end else if (paddr_i == `IRQG_MASK_OFS) begin
                mask <= pwdata_i[8:0];
            end
        end
    end

    // Status clear strobes come from a write of ones; set strobes come from
    // every source pending at the interval end, also one whose request is dropped.
    assign stat_clr = (wr_en && (paddr_i == `IRQG_STAT_OFS)) ? pwdata_i[8:0] : 9'h000;
    assign stat_set = tick ? pend : 9'h000;

    // Sticky status: set on each source pending at the interval end; write one clears; set wins,
    // so an issue that meets a clear in one cycle is never lost.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat <= 9'h000;
        end else begin
            stat <= (stat & ~stat_clr) | stat_set;
        end
    end

    // Level interrupt, high while any unmasked status bit is set.
    assign irq_o = |(stat & mask);

    // Read multiplexer; unmapped offsets read as zero.
    always @* begin
        next_rdata = 32'h00000000;
        if (paddr_i == `IRQG_CTRL_OFS) begin
            next_rdata = ctrl;
        end else if (paddr_i == `IRQG_VEC_LO_OFS) begin
            next_rdata = vec_map[31:0];
        end else if (paddr_i == `IRQG_VEC_HI_OFS) begin
            next_rdata = {28'h0000000, vec_map[35:32]};
        end else if (paddr_i == `IRQG_STAT_OFS) begin
            next_rdata = {23'h000000, stat};
        end else if (paddr_i == `IRQG_MASK_OFS) begin
            next_rdata = {23'h000000, mask};
        end else if (paddr_i == `IRQG_PEND_OFS) begin
            next_rdata = {23'h000000, pend};
        end
    end

    // Read data registered in the setup phase and held until the next read,
    // so it stands through the access phase without a wait state.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h00000000;
        end else if (rd_en) begin
            prdata_o <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the interrupt request generator.
`timescale 1ns/10ps
`default_nettype none
`include "irqg_map.vh"
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [7:0]  si_term_i = 8'h00;
    logic        log_full_i = 1'b0;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, irq_o, svc_vld;
    wire  [8:0]  host_req_o;
    wire  [3:0]  svc;
    logic [3:0]  q[$];
    logic [31:0] rd;
    logic [7:0]  sub;
    integer      seed = 32'h4CCC2977;
    integer      err_total = 0;
    integer      n_compared = 0;
    integer      t;
    irqg_top dut (.*);
    irqg_host u_host (.clk_i, .rst_n_i, .host_req_i(host_req_o), .svc_o(svc), .svc_vld_o(svc_vld));
    // Clock at 25 MHz.
    initial forever #20 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
        n_compared++;
        if (e !== s) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        chk(a > 12'h014, pslverr_o, "pslverr");
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic fire(input logic [7:0] m, input logic lf);
        si_term_i  <= m;
        log_full_i <= lf;
        repeat (8) @(posedge clk_i);
        si_term_i  <= 8'h00;
        log_full_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic sync;
        for (t = 0; t < 3000 && host_req_o === 9'h000; t++) @(posedge clk_i);
        chk(1, t < 3000, "request seen");
        @(posedge clk_i);
    endtask
    // Each serviced vector is matched against the oldest expectation.
    always @(posedge clk_i) begin
        if (svc_vld === 1'b1) chk(q.size() ? q.pop_front() : 4'hF, svc, "vector");
    end
    // Watchdog.
    initial begin
        repeat (80000) @(posedge clk_i);
        err_total++;
        print_verdict;
    end
    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            apb(0, 12'(i * 4), 0);
            chk(0, rd, "reset or unmapped read");
        end
        apb(1, `IRQG_VEC_LO_OFS, 32'h87654321);
        apb(1, `IRQG_VEC_HI_OFS, 32'h9);
        apb(1, `IRQG_MASK_OFS, 32'h1FF);
        apb(1, `IRQG_CTRL_OFS, 32'h1);
        apb(0, `IRQG_VEC_LO_OFS, 0);
        chk(32'h87654321, rd, "vector map");
        sub = $random(seed) | 8'h01;
        for (int k = 0; k < 8; k++) if (sub[k]) q.push_back(4'(k + 1));
        fire(sub, 0);
        sync;
        chk(1, irq_o, "irq set");
        apb(1, `IRQG_MASK_OFS, 0);
        chk(0, irq_o, "irq masked");
        apb(1, `IRQG_MASK_OFS, 32'h1FF);
        chk(1, irq_o, "irq unmasked");
        apb(1, `IRQG_STAT_OFS, 32'h1FF);
        chk(0, irq_o, "irq cleared");
        q.push_back(4'h1);
        repeat (3) fire(8'h01, 0);
        sync;
        q.push_back(4'h1);
        fire(8'h01, 0);
        sync;
        chk(1, t <= 1250, "fast delay");
        apb(1, `IRQG_VEC_LO_OFS, 32'h876543A0);
        apb(1, `IRQG_CTRL_OFS, 0);
        fire(8'h03, 1);
        repeat (2600) @(posedge clk_i);
        apb(1, `IRQG_CTRL_OFS, 32'h1);
        q.push_back(4'h9);
        fire(8'h00, 1);
        sync;
        for (int c = 3; c < 6; c += 2) begin
            apb(1, `IRQG_CTRL_OFS, c);
            q.push_back(4'h3);
            fire(8'h04, 0);
            sync;
            q.push_back(4'h3);
            fire(8'h04, 0);
            sync;
            chk(1, t > 1250 && t <= 2500, "slow delay");
        end
        repeat (20) @(posedge clk_i);
        chk(0, q.size(), "queue empty");
        print_verdict;
    end
endmodule
`default_nettype wire
